// ==== rtl/cmr_pkg.sv ====
package cmr_pkg;

    localparam int ADDR_W = 15;
    localparam int DATA_W = 16;
    localparam int CORE_W = 17;
    localparam int PARITY_BIT = 16;
    localparam int DI_BIT = 15;
    localparam int STACK_LSB = 13;
    localparam int STACK_W = 2;
    localparam int PAGE_LSB = 10;
    localparam int PAGE_W = 3;
    localparam int WORD_W = 10;
    localparam int ACC_LIMIT = 2;
    localparam int STACKS = 2;
    localparam logic [ADDR_W-1:0] ACC_A_ADDR = 15'h0000;
    localparam logic [ADDR_W-1:0] ACC_B_ADDR = 15'h0001;
    localparam logic [ADDR_W-1:0] MAR_RESET = 15'h0000;
    localparam logic [DATA_W-1:0] MDR_RESET = 16'h0000;
    localparam real CLOCK_MHZ = 250.0;
    localparam real READ_NS = 350.0;
    localparam real WRITE_NS = 350.0;
    localparam int READ_CYC = (int'($ceil(READ_NS * CLOCK_MHZ / 1000.0)) < 1) ? 1 :
        int'($ceil(READ_NS * CLOCK_MHZ / 1000.0));
    localparam int WRITE_CYC = (int'($ceil(WRITE_NS * CLOCK_MHZ / 1000.0)) < 1) ? 1 :
        int'($ceil(WRITE_NS * CLOCK_MHZ / 1000.0));
    localparam int CNT_W = 8;

    typedef enum logic [1:0] {
        CMR_PH_FETCH = 2'b00,
        CMR_PH_INDIRECT = 2'b01,
        CMR_PH_EXECUTE = 2'b10,
        CMR_PH_OTHER = 2'b11
    } cmr_phase_e;

    typedef enum logic [1:0] {
        CMR_SRC_PANEL = 2'b00,
        CMR_SRC_FETCH = 2'b01,
        CMR_SRC_OPERAND = 2'b10
    } cmr_src_e;

    typedef enum logic [2:0] {
        CMR_IDLE = 3'b000,
        CMR_READ = 3'b001,
        CMR_RESTORE = 3'b010,
        CMR_DELIVER = 3'b011
    } cmr_state_e;

    typedef struct packed {
        logic [STACKS-1:0] stack_sel;
        logic [PAGE_W-1:0] page;
        logic [WORD_W-1:0] word;
        logic upper_module;
        logic acc_sel;
        logic acc_b;
    } cmr_sel_s;

    typedef struct packed {
        logic read;
        logic write;
        logic [CORE_W-1:0] inhibit;
    } cmr_drive_s;

endpackage : cmr_pkg

// ==== rtl/cmr_decode.sv ====
`timescale 1ns/1ps
module cmr_decode (
    input wire logic [cmr_pkg::ADDR_W-1:0] addr,
    output cmr_pkg::cmr_sel_s sel
);

    // bit 15 never reaches here, so direct/indirect cannot alter selection
    always_comb begin
        sel = '0;
        sel.page = addr[cmr_pkg::PAGE_LSB +: cmr_pkg::PAGE_W];
        sel.word = addr[cmr_pkg::WORD_W-1:0];
        sel.upper_module = addr[cmr_pkg::PAGE_LSB+cmr_pkg::PAGE_W-1];
        if (addr < cmr_pkg::ADDR_W'(cmr_pkg::ACC_LIMIT)) begin
            sel.acc_sel = 1'b1;
            sel.acc_b = (addr == cmr_pkg::ACC_B_ADDR);
        end else if (addr[cmr_pkg::STACK_LSB +: cmr_pkg::STACK_W] < 2'(cmr_pkg::STACKS)) begin
            sel.stack_sel[addr[cmr_pkg::STACK_LSB]] = 1'b1;
        end
    end

endmodule : cmr_decode

// ==== rtl/cmr_timer.sv ====
`timescale 1ns/1ps
module cmr_timer #(
    parameter int WIDTH = cmr_pkg::CNT_W
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic start,
    input wire logic [WIDTH-1:0] length,
    output logic done
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic run;
    } cmr_timer_s;

    cmr_timer_s st_q;
    cmr_timer_s st_d;

    initial begin
        if (WIDTH < 2) $error("timer width too small");
    end

    always_comb begin
        st_d = st_q;
        if (start) begin
            st_d.run = 1'b1;
            st_d.count = length;
        end else if (st_q.run) begin
            st_d.count = st_q.count - WIDTH'(1);
            if (st_q.count == WIDTH'(1)) begin
                st_d.run = 1'b0;
            end
        end
    end

    assign done = st_q.run && (st_q.count == WIDTH'(1));

    always_ff @(posedge clock) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule : cmr_timer

// ==== rtl/cmr_core_read.sv ====
`timescale 1ns/1ps
// Behaviour
// - every read zeroes all 17 cores of the location until restored
// - a rewrite of the same location starts right after each read
// - address held during rewrite; write of one into every bit
// - inhibit blocks the one-write for each zero bit captured
// - panel display readout ignored while running, accepted when halted
// - data key loads keyed address and starts one memory cycle
// - address decode enables the single driver of the selected location
// - sense outputs captured into data register at end of read half
// - display: data register to source bus, io bus, display latch
// - program counter incremented at start of instruction execution
// - entering fetch copies program counter into address register
// - fetch reads addressed word and uses it as next instruction
// - fetched word goes to instruction register and mapper in the same cycle
// - only fetch-phase words are instructions; others operands or addresses
// - bit 15 ignored; 14..13 stack, 12..10 page, 9..0 word
// - first stack 00002-17777, lower pages 0-3, second from 20000
// - addresses 00000 and 00001 go to accumulators, not core
// - 16 data bits plus parity bit 16 read and restored together
module cmr_core_read #(
    parameter int READ_CYCLES = cmr_pkg::READ_CYC,
    parameter int WRITE_CYCLES = cmr_pkg::WRITE_CYC
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic halted,
    input wire logic panel_addr_select,
    input wire logic [cmr_pkg::DATA_W-1:0] panel_switches,
    input wire logic panel_data_key,
    input wire logic fetch_enter,
    input wire logic exec_start,
    input wire cmr_pkg::cmr_phase_e phase,
    input wire logic operand_req,
    input wire logic [cmr_pkg::ADDR_W-1:0] operand_addr,
    input wire logic [cmr_pkg::DATA_W-1:0] acc_a,
    input wire logic [cmr_pkg::DATA_W-1:0] acc_b,
    input wire logic [cmr_pkg::CORE_W-1:0] sense,
    output logic busy,
    output logic accept,
    output cmr_pkg::cmr_sel_s core_sel,
    output cmr_pkg::cmr_drive_s core_drive,
    output logic [cmr_pkg::ADDR_W-1:0] mar,
    output logic [cmr_pkg::CORE_W-1:0] mdr,
    output logic [cmr_pkg::ADDR_W-1:0] pc,
    output logic [cmr_pkg::DATA_W-1:0] source_bus,
    output logic [cmr_pkg::DATA_W-1:0] io_bus,
    output logic [cmr_pkg::DATA_W-1:0] display,
    output logic [cmr_pkg::DATA_W-1:0] instr,
    output logic [7:0] micro_start,
    output logic instr_valid,
    output logic operand_valid,
    output logic [cmr_pkg::DATA_W-1:0] operand_word
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        cmr_pkg::cmr_state_e state;
        cmr_pkg::cmr_src_e src;
        logic [cmr_pkg::ADDR_W-1:0] mar;
        logic [cmr_pkg::CORE_W-1:0] mdr;
        logic [cmr_pkg::ADDR_W-1:0] pc;
        logic addr_sel_armed;
        logic key_prev;
        logic [cmr_pkg::DATA_W-1:0] display;
        logic [cmr_pkg::DATA_W-1:0] instr;
        logic [7:0] micro_start;
        logic instr_valid;
        logic operand_valid;
        logic [cmr_pkg::DATA_W-1:0] operand_word;
        logic gate_src;
        logic gate_io;
    } cmr_state_s;

    cmr_state_s st_q;
    cmr_state_s st_d;
    cmr_pkg::cmr_sel_s sel;
    logic timer_start;
    logic [cmr_pkg::CNT_W-1:0] timer_len;
    logic timer_done;
    logic key_press;
    logic panel_go;
    logic fetch_go;

    initial begin
        if (READ_CYCLES < 1 || READ_CYCLES >= (1 << cmr_pkg::CNT_W)) $error("read cycles out of range");
        if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << cmr_pkg::CNT_W)) $error("write cycles out of range");
    end

    cmr_decode u_decode (
        .addr(st_q.mar),
        .sel(sel)
    );

    cmr_timer #(
        .WIDTH(cmr_pkg::CNT_W)
    ) u_timer (
        .clock(clock),
        .reset(reset),
        .start(timer_start),
        .length(timer_len),
        .done(timer_done)
    );

    // crude microcode mapper: opcode and d/i bits give the routine start
    function automatic logic [7:0] map_start(input logic [cmr_pkg::DATA_W-1:0] w);
        map_start = {w[15:11], 3'h0};
    endfunction : map_start

    ////////////////////////////////////////////////////////////////////////
    assign key_press = panel_data_key && !st_q.key_prev;
    assign panel_go = key_press && halted && st_q.addr_sel_armed;
    assign fetch_go = fetch_enter && (phase == cmr_pkg::CMR_PH_FETCH);

    always_comb begin
        st_d = st_q;
        timer_start = 1'b0;
        timer_len = cmr_pkg::CNT_W'(READ_CYCLES);
        st_d.key_prev = panel_data_key;
        st_d.instr_valid = 1'b0;
        st_d.operand_valid = 1'b0;
        st_d.gate_src = 1'b0;
        st_d.gate_io = st_q.gate_src;
        if (panel_addr_select) begin
            st_d.addr_sel_armed = 1'b1;
        end
        if (!halted) begin
            st_d.addr_sel_armed = 1'b0;
        end
        if (exec_start) begin
            st_d.pc = st_q.pc + cmr_pkg::ADDR_W'(1);
        end
        if (st_q.gate_io) begin
            st_d.display = io_bus;
        end
        case (st_q.state)
            cmr_pkg::CMR_IDLE: begin
                if (panel_go) begin
                    st_d.mar = panel_switches[cmr_pkg::ADDR_W-1:0];
                    st_d.src = cmr_pkg::CMR_SRC_PANEL;
                    st_d.state = cmr_pkg::CMR_READ;
                    timer_start = 1'b1;
                end else if (fetch_go) begin
                    st_d.mar = st_q.pc;
                    st_d.src = cmr_pkg::CMR_SRC_FETCH;
                    st_d.state = cmr_pkg::CMR_READ;
                    timer_start = 1'b1;
                end else if (operand_req && phase != cmr_pkg::CMR_PH_FETCH) begin
                    st_d.mar = operand_addr;
                    st_d.src = cmr_pkg::CMR_SRC_OPERAND;
                    st_d.state = cmr_pkg::CMR_READ;
                    timer_start = 1'b1;
                end
            end
            cmr_pkg::CMR_READ: begin
                if (timer_done) begin
                    if (sel.acc_sel) begin
                        st_d.mdr = {1'b0, sel.acc_b ? acc_b : acc_a};
                    end else begin
                        st_d.mdr = sense;
                    end
                    st_d.state = cmr_pkg::CMR_RESTORE;
                    timer_start = 1'b1;
                    timer_len = cmr_pkg::CNT_W'(WRITE_CYCLES);
                end
            end
            cmr_pkg::CMR_RESTORE: begin
                if (timer_done) begin
                    st_d.state = cmr_pkg::CMR_DELIVER;
                end
            end
            cmr_pkg::CMR_DELIVER: begin
                st_d.state = cmr_pkg::CMR_IDLE;
                case (st_q.src)
                    cmr_pkg::CMR_SRC_PANEL: begin
                        st_d.gate_src = 1'b1;
                    end
                    cmr_pkg::CMR_SRC_FETCH: begin
                        st_d.instr = st_q.mdr[cmr_pkg::DATA_W-1:0];
                        st_d.micro_start = map_start(st_q.mdr[cmr_pkg::DATA_W-1:0]);
                        st_d.instr_valid = 1'b1;
                    end
                    default: begin
                        st_d.operand_word = st_q.mdr[cmr_pkg::DATA_W-1:0];
                        st_d.operand_valid = 1'b1;
                    end
                endcase
            end
            default: begin
                st_d.state = cmr_pkg::CMR_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        core_sel = sel;
        core_drive = '0;
        if (st_q.state == cmr_pkg::CMR_READ && !sel.acc_sel) begin
            core_drive.read = 1'b1;
        end
        if (st_q.state == cmr_pkg::CMR_RESTORE && !sel.acc_sel) begin
            core_drive.write = 1'b1;
            core_drive.inhibit = ~st_q.mdr;
        end
        if (st_q.state == cmr_pkg::CMR_IDLE || st_q.state == cmr_pkg::CMR_DELIVER) begin
            core_sel.stack_sel = '0;
        end
    end

    assign busy = (st_q.state != cmr_pkg::CMR_IDLE);
    assign accept = timer_start && (st_q.state == cmr_pkg::CMR_IDLE);
    assign mar = st_q.mar;
    assign mdr = st_q.mdr;
    assign pc = st_q.pc;
    assign source_bus = st_q.gate_src ? st_q.mdr[cmr_pkg::DATA_W-1:0] : 16'h0000;
    assign io_bus = st_q.gate_io ? st_q.mdr[cmr_pkg::DATA_W-1:0] : 16'h0000;
    assign display = st_q.display;
    assign instr = st_q.instr;
    assign micro_start = st_q.micro_start;
    assign instr_valid = st_q.instr_valid;
    assign operand_valid = st_q.operand_valid;
    assign operand_word = st_q.operand_word;

    always_ff @(posedge clock) begin
        if (reset) begin
            st_q <= '0;
            st_q.mar <= cmr_pkg::MAR_RESET;
        end else begin
            st_q <= st_d;
        end
    end

endmodule : cmr_core_read

// ==== testbench/cmr_core_model.sv ====
`timescale 1ns/1ps
module cmr_core_model (
    input wire logic clock,
    input wire cmr_pkg::cmr_sel_s core_sel,
    input wire cmr_pkg::cmr_drive_s core_drive,
    output logic [cmr_pkg::CORE_W-1:0] sense
);
    logic [cmr_pkg::CORE_W-1:0] mem [0:16383];
    logic [cmr_pkg::CORE_W-1:0] held_q = '0;
    logic [cmr_pkg::CORE_W-1:0] last_q = '0;
    logic rd_q = 1'b0;
    logic [13:0] key;
    assign key = {core_sel.stack_sel[1], core_sel.page, core_sel.word};
    // sense only valid in read half
    // outside it the lines toggle, so a late sample cannot pass by luck
    assign sense = core_drive.read ? (rd_q ? held_q : mem[key]) : ~last_q;
    always @(posedge clock) begin
        rd_q <= core_drive.read;
        last_q <= sense;
        if (core_drive.read && !rd_q) begin
            held_q <= mem[key];
            mem[key] <= '0;
        end
        if (core_drive.write) begin
            mem[key] <= ~core_drive.inhibit;
        end
    end
    initial begin
        for (int i = 0; i < 16384; i++) begin
            mem[i] = '0;
        end
    end
endmodule : cmr_core_model

// ==== testbench/cmr_core_read_chk.sv ====
`timescale 1ns/1ps
module cmr_core_read_chk #(
    parameter int READ_CYCLES = 2,
    parameter int WRITE_CYCLES = 2
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic halted,
    input wire logic fetch_enter,
    input wire logic exec_start,
    input wire cmr_pkg::cmr_phase_e phase,
    input wire logic [cmr_pkg::CORE_W-1:0] sense,
    input wire logic busy,
    input wire logic accept,
    input wire cmr_pkg::cmr_drive_s core_drive,
    input wire logic [cmr_pkg::ADDR_W-1:0] mar,
    input wire logic [cmr_pkg::CORE_W-1:0] mdr,
    input wire logic [cmr_pkg::ADDR_W-1:0] pc,
    input wire logic [cmr_pkg::DATA_W-1:0] source_bus,
    input wire logic [cmr_pkg::DATA_W-1:0] io_bus,
    input wire logic [cmr_pkg::DATA_W-1:0] display,
    input wire logic [cmr_pkg::DATA_W-1:0] instr,
    input wire logic [7:0] micro_start,
    input wire logic instr_valid
);
    logic [7:0] rd_q;
    logic [7:0] wr_q;
    // counters, since the half lengths are parameters
    always_ff @(posedge clock) begin
        rd_q <= (reset || !core_drive.read) ? 8'h00 : rd_q + 8'h01;
        wr_q <= (reset || !core_drive.write) ? 8'h00 : wr_q + 8'h01;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_read_end; $fell(core_drive.read); endsequence
    sequence s_take_fetch; fetch_enter && accept && phase == cmr_pkg::CMR_PH_FETCH; endsequence
    sequence s_io_to_lamp; io_bus == $past(source_bus) ##1 display == $past(io_bus); endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_busy_refuse: assert property (busy |-> !accept)
        else $error("request taken while busy");
    a_read_restore: assert property (s_read_end |-> core_drive.write)
        else $error("no restore right after read");
    a_read_capture: assert property (s_read_end |-> mdr == $past(sense))
        else $error("data register missed sense word");
    a_read_length: assert property (s_read_end |-> rd_q == READ_CYCLES)
        else $error("read half length wrong");
    a_restore_len: assert property ($fell(core_drive.write) |-> wr_q == WRITE_CYCLES)
        else $error("restore length wrong");
    a_inhibit_word: assert property (core_drive.write |-> core_drive.inhibit == ~mdr)
        else $error("inhibit not inverse of word");
    a_mar_held: assert property (core_drive.write |-> $stable(mar))
        else $error("address moved during restore");
    a_fetch_addr: assert property (s_take_fetch |=> mar == $past(pc))
        else $error("fetch did not load pc");
    a_pc_step: assert property (exec_start |=> pc == $past(pc) + 15'h0001)
        else $error("pc not stepped");
    a_micro_map: assert property (instr_valid |-> micro_start == {instr[15:11], 3'b000})
        else $error("mapper start wrong");
    a_display_path: assert property (io_bus != 16'h0000 |-> s_io_to_lamp)
        else $error("display path broken");
    a_display_hold: assert property (!halted && !busy |=> $stable(display))
        else $error("display changed while running");
endmodule : cmr_core_read_chk
bind cmr_core_read cmr_core_read_chk #(.READ_CYCLES(READ_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)) u_chk (
    .clock(clock), .reset(reset), .halted(halted), .fetch_enter(fetch_enter), .exec_start(exec_start),
    .phase(phase), .sense(sense), .busy(busy), .accept(accept), .core_drive(core_drive), .mar(mar),
    .mdr(mdr), .pc(pc), .source_bus(source_bus), .io_bus(io_bus), .display(display), .instr(instr),
    .micro_start(micro_start), .instr_valid(instr_valid));

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
    logic clock = 1'b0, reset = 1'b1, halted = 1'b0, panel_addr_select = 1'b0, panel_data_key = 1'b0;
    logic fetch_enter = 1'b0, exec_start = 1'b0, operand_req = 1'b0;
    logic [15:0] panel_switches = 16'h0000, acc_a = 16'h1234, acc_b = 16'h5678;
    logic [14:0] operand_addr = 15'h0000;
    cmr_pkg::cmr_phase_e phase = cmr_pkg::CMR_PH_OTHER;
    logic [16:0] sense, mdr;
    logic busy, accept, instr_valid, operand_valid;
    cmr_pkg::cmr_sel_s core_sel;
    cmr_pkg::cmr_drive_s core_drive;
    logic [14:0] mar, pc;
    logic [15:0] source_bus, io_bus, display, instr, operand_word;
    logic [7:0] micro_start;
    int fail_count = 0;
    int checks = 0;
    int operand_pulses = 0;
    always #2 clock = ~clock;
    // operand_valid stands one cycle only, so it is counted as it passes
    always @(posedge clock) begin
        if (operand_valid === 1'b1) operand_pulses++;
    end
    // short halves keep the run brief
    cmr_core_read #(.READ_CYCLES(2), .WRITE_CYCLES(2)) u_cmr_core_read (
        .clock(clock), .reset(reset), .halted(halted), .panel_addr_select(panel_addr_select),
        .panel_switches(panel_switches), .panel_data_key(panel_data_key), .fetch_enter(fetch_enter),
        .exec_start(exec_start), .phase(phase), .operand_req(operand_req), .operand_addr(operand_addr),
        .acc_a(acc_a), .acc_b(acc_b), .sense(sense), .busy(busy), .accept(accept), .core_sel(core_sel),
        .core_drive(core_drive), .mar(mar), .mdr(mdr), .pc(pc), .source_bus(source_bus), .io_bus(io_bus),
        .display(display), .instr(instr), .micro_start(micro_start), .instr_valid(instr_valid),
        .operand_valid(operand_valid), .operand_word(operand_word));
    cmr_core_model u_cmr_core_model (.clock(clock), .core_sel(core_sel), .core_drive(core_drive), .sense(sense));
    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp_w(input logic [16:0] got, input logic [16:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_w
    task automatic cmp_a(input logic [14:0] got, input logic [14:0] exp);
        cmp_w({2'b00, got}, {2'b00, exp});
    endtask : cmp_a
    task automatic end_sim;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (busy !== 1'b0 && n < 400);
        if (busy !== 1'b0) fail_count++;
        repeat (3) @(posedge clock);
        #1;
    endtask : wait_idle
    // bit 15 of the keyed address set on purpose: it must not matter
    task automatic go_panel(input logic [14:0] a);
        @(posedge clock) panel_addr_select <= 1'b1;
        panel_switches <= {1'b1, a};
        @(posedge clock) panel_addr_select <= 1'b0;
        panel_data_key <= 1'b1;
        @(posedge clock) panel_data_key <= 1'b0;
        wait_idle();
    endtask : go_panel
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_display;
        logic [14:0] a [4] = '{15'h0002, 15'h1FFF, 15'h2000, 15'h3FFF};
        logic [16:0] d [4] = '{17'h1A5C3, 17'h0FFFF, 17'h10000, 17'h00001};
        @(posedge clock) halted <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            u_cmr_core_model.mem[a[i][13:0]] = d[i];
            go_panel(a[i]);
            cmp_w({1'b0, display}, {1'b0, d[i][15:0]});
            cmp_w(mdr, d[i]);
            cmp_a(mar, a[i]);
            cmp_w(u_cmr_core_model.mem[a[i][13:0]], d[i]);
        end
        $display("test display done");
    endtask : t_display
    task automatic t_running;
        @(posedge clock) halted <= 1'b0;
        u_cmr_core_model.mem[5] = 17'h0BEEF;
        go_panel(15'h0005);
        cmp_w({1'b0, display}, 17'h00001);
        cmp_a(mar, 15'h3FFF);
        $display("test running done");
    endtask : t_running
    task automatic t_fetch;
        logic [16:0] d = 17'h19ABC;
        repeat (3) begin
            @(posedge clock) exec_start <= 1'b1;
            @(posedge clock) exec_start <= 1'b0;
        end
        #1;
        cmp_a(pc, 15'h0003);
        u_cmr_core_model.mem[3] = d;
        @(posedge clock) phase <= cmr_pkg::CMR_PH_FETCH;
        fetch_enter <= 1'b1;
        @(posedge clock) fetch_enter <= 1'b0;
        // second request while busy must be dropped
        @(posedge clock) fetch_enter <= 1'b1;
        @(posedge clock) fetch_enter <= 1'b0;
        wait_idle();
        cmp_a(mar, 15'h0003);
        cmp_w({1'b0, instr}, {1'b0, d[15:0]});
        cmp_w({9'h000, micro_start}, {9'h000, d[15:11], 3'b000});
        cmp_w(u_cmr_core_model.mem[3], d);
        $display("test fetch done");
    endtask : t_fetch
    task automatic t_operand;
        logic [14:0] a [4] = '{15'h0000, 15'h0001, 15'h2000, 15'h1FFF};
        logic [15:0] e [4] = '{16'h0000, 16'h0000, 16'h0F0F, 16'hC3C3};
        e[0] = acc_a;
        e[1] = acc_b;
        for (int i = 0; i < 4; i++) begin
            if (i > 1) u_cmr_core_model.mem[a[i][13:0]] = {1'b0, e[i]};
            @(posedge clock) phase <= cmr_pkg::CMR_PH_EXECUTE;
            operand_addr <= a[i];
            operand_req <= 1'b1;
            @(posedge clock) operand_req <= 1'b0;
            wait_idle();
            cmp_w({1'b0, operand_word}, {1'b0, e[i]});
            cmp_w(17'(operand_pulses), 17'(i + 1));
            cmp_w({1'b0, instr}, 17'h09ABC);
        end
        $display("test operand done");
    endtask : t_operand
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        t_display();
        t_running();
        t_fetch();
        t_operand();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        end_sim();
    end
endmodule : tb
